// ### mrl_pkg.sv
package mrl_pkg;
    // Register addresses on the mode register bus
    localparam logic [7:0] MRL_ADDR_CAPS = 8'h00;
    localparam logic [7:0] MRL_ADDR_LAT = 8'h02;
    localparam logic [7:0] MRL_ADDR_DRV = 8'h03;
    localparam logic [7:0] MRL_ADDR_TEMP = 8'h04;
    // Latency register fields
    localparam int MRL_LAT_CODE_LSB = 0;
    localparam int MRL_LAT_WRE_BIT = 4;
    localparam int MRL_LAT_SET_BIT = 6;
    localparam int MRL_LAT_WLEV_BIT = 7;
    localparam logic [7:0] MRL_LAT_RST = 8'h18;
    localparam logic [7:0] MRL_LAT_WMASK = 8'hDF;
    // Drive register fields
    localparam logic [7:0] MRL_DRV_RST = 8'h02;
    localparam logic [7:0] MRL_DRV_WMASK = 8'h0F;
    // Temperature register fields
    localparam int MRL_TUF_BIT = 7;
    localparam logic [2:0] MRL_RATE_RST = 3'h3;
    // Capability bits
    localparam int MRL_CAP_LOW_BIT = 7;
    localparam int MRL_CAP_ALT_BIT = 6;
    // Value returned for write-only registers
    localparam logic [7:0] MRL_UNDEF_DATA = 8'h00;
    // APB register offsets of the controller
    localparam logic [7:0] MRL_APB_CTRL = 8'h00;
    localparam logic [7:0] MRL_APB_WDATA = 8'h04;
    localparam logic [7:0] MRL_APB_STAT = 8'h08;
    localparam logic [7:0] MRL_APB_RDATA = 8'h0C;
    localparam logic [7:0] MRL_APB_STATUS = 8'h10;
    localparam int MRL_CTRL_GO_BIT = 31;
    localparam int MRL_CTRL_RD_BIT = 30;

    // Latency decode: {valid, read latency, write latency}
    function automatic logic [10:0] mrl_lat_decode(input logic [3:0] code,
                                                   input logic set_b);
        logic [10:0] r;
        r = 11'h000;
        case (code)
            4'h1: r = {1'b1, 5'd3, 5'd1};
            4'h4: r = {1'b1, 5'd6, 5'd3};
            4'h6: r = {1'b1, 5'd8, 5'd4};
            4'h7: r = {1'b1, 5'd9, 5'd5};
            4'h8: r = set_b ? {1'b1, 5'd10, 5'd8} : {1'b1, 5'd10, 5'd6};
            4'h9: r = set_b ? {1'b1, 5'd11, 5'd9} : {1'b1, 5'd11, 5'd6};
            4'hA: r = set_b ? 11'h000 : {1'b1, 5'd12, 5'd6};
            default: r = 11'h000;
        endcase
        return r;
    endfunction : mrl_lat_decode
endpackage : mrl_pkg

// ### mrl_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mrl_if;
    logic cmd_valid;
    logic cmd_read;
    logic [7:0] cmd_addr;
    logic [7:0] cmd_wdata;
    logic rsp_valid;
    logic [7:0] rsp_rdata;
    modport dev (input cmd_valid, cmd_read, cmd_addr, cmd_wdata,
                 output rsp_valid, rsp_rdata);
    modport ctl (output cmd_valid, cmd_read, cmd_addr, cmd_wdata,
                 input rsp_valid, rsp_rdata);
endinterface : mrl_if
`default_nettype wire

// ### mrl_dev.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Set A decodes listed latency codes
// - Set B alternate write latencies
// - Controller picks latency by data rate; mrl_ctl sends whatever code software writes
// - Controller respects code frequency limits; mrl_ctl does not check them
// - Capability register reports low and alt
// - Bit 4 selects write-recovery range
// - Bit 6 selects write latency set
// - Bit 7 enables write leveling
// - Drive field symmetric impedance codes
// - Drive field asymmetric codes, rest reserved
// - Temperature register reports refresh multiplier
// - Controller quarters refresh at 110b; mrl_ctl only sets STATUS bit 9 there
// - Controller adds derating delay; mrl_ctl only flags it in STATUS bit 9
// - Flag set on rate code change
// - Temperature read clears the flag
// - Flag cleared at power-up
// - Bit 2 marks high temperature
// - Controller treats 000b, 111b as fault
// - Reserved writes zero; write-only reads undefined
module mrl_dev
    import mrl_pkg::*;
#(
    parameter logic CAP_LOW = 1'b1,
    parameter logic CAP_ALT = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Command side
    mrl_if.dev bus,
    // Sensor input and decoded controls
    input wire logic [2:0] sensor_rate,
    output logic lat_valid,
    output logic [4:0] read_latency_cycles,
    output logic [4:0] write_latency_cycles,
    output logic write_recovery_range_ext,
    output logic write_latency_set_select,
    output logic write_level_en,
    output logic [3:0] output_drive_strength,
    output logic drive_code_valid,
    output logic high_temp
);
    logic [7:0] lat_ff, nxt_lat;
    logic [7:0] drv_ff, nxt_drv;
    logic [2:0] rate_ff, nxt_rate;
    logic tuf_ff, nxt_tuf;
    logic rsp_ff, nxt_rsp;
    logic [7:0] rd_ff, nxt_rd;
    logic [7:0] caps;
    logic [10:0] dec;

    // Capabilities and latency decode
    always_comb begin
        caps = 8'h00;
        caps[MRL_CAP_LOW_BIT] = CAP_LOW;
        caps[MRL_CAP_ALT_BIT] = CAP_ALT;
        dec = mrl_lat_decode(lat_ff[MRL_LAT_CODE_LSB +: 4],
                             lat_ff[MRL_LAT_SET_BIT]);
    end

    assign lat_valid = dec[10];
    assign read_latency_cycles = dec[9:5];
    assign write_latency_cycles = dec[4:0];
    assign write_recovery_range_ext = lat_ff[MRL_LAT_WRE_BIT];
    assign write_latency_set_select = lat_ff[MRL_LAT_SET_BIT];
    assign write_level_en = lat_ff[MRL_LAT_WLEV_BIT];
    assign output_drive_strength = drv_ff[3:0];
    assign high_temp = rate_ff[2];
    assign bus.rsp_valid = rsp_ff;
    assign bus.rsp_rdata = rd_ff;

    // Drive code validity
    always_comb begin
        case (drv_ff[3:0])
            4'h1, 4'h2, 4'h3: drive_code_valid = 1'b1;
            4'h9, 4'hA, 4'hB: drive_code_valid = 1'b1;
            default: drive_code_valid = 1'b0;
        endcase
    end

    // Register writes, reads and temperature tracking
    always_comb begin
        nxt_lat = lat_ff;
        nxt_drv = drv_ff;
        nxt_rate = sensor_rate;
        nxt_tuf = tuf_ff;
        nxt_rsp = 1'b0;
        nxt_rd = rd_ff;
        if (bus.cmd_valid && !bus.cmd_read) begin
            if (bus.cmd_addr == MRL_ADDR_LAT) begin
                nxt_lat = bus.cmd_wdata & MRL_LAT_WMASK;
            end else if (bus.cmd_addr == MRL_ADDR_DRV) begin
                nxt_drv = bus.cmd_wdata & MRL_DRV_WMASK;
            end
        end
        if (bus.cmd_valid && bus.cmd_read) begin
            nxt_rsp = 1'b1;
            if (bus.cmd_addr == MRL_ADDR_TEMP) begin
                nxt_rd = {tuf_ff, 4'h0, rate_ff};
                nxt_tuf = 1'b0;
            end else if (bus.cmd_addr == MRL_ADDR_CAPS) begin
                nxt_rd = caps;
            end else begin
                nxt_rd = MRL_UNDEF_DATA;
            end
        end
        // Change wins over a clearing read in the same cycle
        if (sensor_rate != rate_ff) begin
            nxt_tuf = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_ff <= MRL_LAT_RST;
            drv_ff <= MRL_DRV_RST;
            rate_ff <= MRL_RATE_RST;
            tuf_ff <= 1'b0;
            rsp_ff <= 1'b0;
            rd_ff <= 8'h00;
        end else begin
            lat_ff <= nxt_lat;
            drv_ff <= nxt_drv;
            rate_ff <= nxt_rate;
            tuf_ff <= nxt_tuf;
            rsp_ff <= nxt_rsp;
            rd_ff <= nxt_rd;
        end
    end
endmodule : mrl_dev
`default_nettype wire

// ### mrl_ctl.sv
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module mrl_ctl
    import mrl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device side
    mrl_if.ctl bus
);
    typedef enum logic [1:0] {
        MRL_IDLE = 2'b00,
        MRL_WAIT = 2'b01
    } mrl_state_e;

    mrl_state_e st_ff, nxt_st;
    logic cv_ff, nxt_cv;
    logic crd_ff, nxt_crd;
    logic [7:0] ca_ff, nxt_ca;
    logic [7:0] cw_ff, nxt_cw;
    logic [7:0] rdat_ff, nxt_rdat;
    logic [7:0] temp_ff, nxt_temp;
    logic done_ff, nxt_done;
    logic [31:0] prd_ff, nxt_prd;
    logic wr_acc, rd_acc;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prd_ff;
    assign bus.cmd_valid = cv_ff;
    assign bus.cmd_read = crd_ff;
    assign bus.cmd_addr = ca_ff;
    assign bus.cmd_wdata = cw_ff;

    // Command sequencing and APB decode
    always_comb begin
        nxt_st = st_ff;
        nxt_cv = 1'b0;
        nxt_crd = crd_ff;
        nxt_ca = ca_ff;
        nxt_cw = cw_ff;
        nxt_rdat = rdat_ff;
        nxt_temp = temp_ff;
        nxt_done = done_ff;
        nxt_prd = prd_ff;
        case (st_ff)
            MRL_IDLE: begin
                if (wr_acc && paddr == MRL_APB_CTRL
                    && pwdata[MRL_CTRL_GO_BIT]) begin
                    nxt_cv = 1'b1;
                    nxt_crd = pwdata[MRL_CTRL_RD_BIT];
                    nxt_ca = pwdata[7:0];
                    nxt_cw = pwdata[15:8] & ((pwdata[7:0] == MRL_ADDR_DRV)
                        ? MRL_DRV_WMASK : MRL_LAT_WMASK);
                    nxt_done = 1'b0;
                    nxt_st = pwdata[MRL_CTRL_RD_BIT] ? MRL_WAIT : MRL_IDLE;
                    nxt_done = !pwdata[MRL_CTRL_RD_BIT];
                end
            end
            MRL_WAIT: begin
                if (bus.rsp_valid) begin
                    nxt_rdat = bus.rsp_rdata;
                    if (ca_ff == MRL_ADDR_TEMP) begin
                        nxt_temp = bus.rsp_rdata;
                    end
                    nxt_done = 1'b1;
                    nxt_st = MRL_IDLE;
                end
            end
            default: nxt_st = MRL_IDLE;
        endcase
        if (rd_acc) begin
            if (paddr == MRL_APB_CTRL) begin
                nxt_prd = {24'h000000, ca_ff};
            end else if (paddr == MRL_APB_STAT) begin
                nxt_prd = {30'h00000000, st_ff != MRL_IDLE, done_ff};
            end else if (paddr == MRL_APB_RDATA) begin
                nxt_prd = {24'h000000, rdat_ff};
            end else if (paddr == MRL_APB_STATUS) begin
                // Bit 8: fault code, bit 9: derating needed
                nxt_prd = {22'h000000, temp_ff[2:0] == 3'h6,
                    temp_ff[2:0] == 3'h0 || temp_ff[2:0] == 3'h7,
                    temp_ff};
            end else begin
                nxt_prd = 32'h00000000;
            end
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= MRL_IDLE;
            cv_ff <= 1'b0;
            crd_ff <= 1'b0;
            ca_ff <= 8'h00;
            cw_ff <= 8'h00;
            rdat_ff <= 8'h00;
            temp_ff <= 8'h00;
            done_ff <= 1'b0;
            prd_ff <= 32'h00000000;
        end else begin
            st_ff <= nxt_st;
            cv_ff <= nxt_cv;
            crd_ff <= nxt_crd;
            ca_ff <= nxt_ca;
            cw_ff <= nxt_cw;
            rdat_ff <= nxt_rdat;
            temp_ff <= nxt_temp;
            done_ff <= nxt_done;
            prd_ff <= nxt_prd;
        end
    end
endmodule : mrl_ctl
`default_nettype wire

// ### mrl_props.sv
`timescale 1ns/100ps
`default_nettype none
module mrl_props
    import mrl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Command link
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_rdata
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Request shapes on the link
    sequence rd_req;
        cmd_valid && cmd_read;
    endsequence
    sequence rd_at(logic [7:0] a);
        cmd_valid && cmd_read && cmd_addr == a;
    endsequence
    sequence wr_at(logic [7:0] a);
        cmd_valid && !cmd_read && cmd_addr == a;
    endsequence
    // Answer timing and data
    a_read_answered: assert property (rd_req |=> rsp_valid)
        else $error("read not answered");
    a_write_silent: assert property (cmd_valid && !cmd_read |=> !rsp_valid)
        else $error("write answered");
    a_rsp_caused: assert property (rsp_valid |-> $past(cmd_valid) && $past(cmd_read))
        else $error("stray answer");
    a_rdata_held: assert property (rsp_valid ##1 !rsp_valid |-> $stable(rsp_rdata))
        else $error("read data moved");
    a_temp_rsv_zero: assert property (rd_at(MRL_ADDR_TEMP) |=> rsp_rdata[6:3] == 4'h0)
        else $error("temp reserved bits set");
    a_wo_undef: assert property (rd_at(MRL_ADDR_LAT) |=> rsp_rdata == MRL_UNDEF_DATA)
        else $error("write-only read data");
    a_caps_rsv_zero: assert property (rd_at(MRL_ADDR_CAPS) |=> rsp_rdata[5:0] == 6'h00)
        else $error("caps reserved bits set");
    a_drv_wr_rsv: assert property (wr_at(MRL_ADDR_DRV) |-> cmd_wdata[7:4] == 4'h0)
        else $error("drive reserved bits written");
endmodule : mrl_props
`default_nettype wire

// ### mode_reg_latency_drive_temp_tb.sv
`timescale 1ns/100ps
`default_nettype none
module mode_reg_latency_drive_temp_tb
    import mrl_pkg::*;
;
    localparam logic [3:0] LCODE [7] = '{4'h1, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
    localparam logic [4:0] RLAT [7] = '{5'h03, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C};
    localparam logic [4:0] WLA [7] = '{5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h06, 5'h06};
    localparam logic [4:0] WLB [7] = '{5'h01, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09, 5'h00};
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] sensor_rate;
    logic lat_valid, wre, wsel, wlev, dcv, high_temp;
    logic [4:0] rl, wl;
    logic [3:0] ds;
    int error_cnt, n_checks, cycles;
    mrl_if bus_if ();
    mrl_dev u_mrl_dev (.pclk(pclk), .presetn(presetn), .bus(bus_if),
        .sensor_rate(sensor_rate), .lat_valid(lat_valid),
        .read_latency_cycles(rl), .write_latency_cycles(wl),
        .write_recovery_range_ext(wre), .write_latency_set_select(wsel),
        .write_level_en(wlev), .output_drive_strength(ds),
        .drive_code_valid(dcv), .high_temp(high_temp));
    mrl_ctl u_mrl_ctl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if));
    mrl_props u_mrl_props (.pclk(pclk), .presetn(presetn),
        .cmd_valid(bus_if.cmd_valid), .cmd_read(bus_if.cmd_read),
        .cmd_addr(bus_if.cmd_addr), .cmd_wdata(bus_if.cmd_wdata),
        .rsp_valid(bus_if.rsp_valid), .rsp_rdata(bus_if.rsp_rdata));
    // Clock and hang guard
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            final_report();
        end
    end
    // Compare one result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        chk(pslverr, 1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // One mode register command through the controller
    task automatic mr(input logic rd, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        logic [31:0] r;
        apb(1'b1, MRL_APB_CTRL, {1'b1, rd, 14'h0, d, a}, r);
        repeat (3) @(posedge pclk);
        r = 32'h0;
        while (r[1:0] !== 2'b01) apb(1'b0, MRL_APB_STAT, 32'h0, r);
        apb(1'b0, MRL_APB_RDATA, 32'h0, r);
        q = r[7:0];
    endtask : mr
    task automatic t_reset();
        logic [7:0] q;
        chk({lat_valid, rl, wl}, {1'b1, 5'h0A, 5'h06});
        chk({wlev, wsel, wre, ds}, 7'h12);
        mr(1'b1, MRL_ADDR_TEMP, 8'h00, q);
        chk(q, 8'h03);
    endtask : t_reset
    task automatic t_latency();
        logic [7:0] q;
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 7; i++) begin
                mr(1'b0, MRL_ADDR_LAT, {s[0], s[0], 1'b1, !s[0], LCODE[i]}, q);
                if (s == 1 && i == 6) chk(lat_valid, 1'b0);
                else chk({lat_valid, rl, wl}, {1'b1, RLAT[i], s ? WLB[i] : WLA[i]});
                chk({wlev, wsel, wre}, {s[0], s[0], !s[0]});
            end
        end
        mr(1'b0, MRL_ADDR_LAT, 8'h02, q);
        chk(lat_valid, 1'b0);
    endtask : t_latency
    task automatic t_drive();
        logic [7:0] q;
        for (int c = 0; c < 16; c++) begin
            mr(1'b0, MRL_ADDR_DRV, {4'hF, c[3:0]}, q);
            chk({dcv, ds}, {c inside {1, 2, 3, 9, 10, 11}, c[3:0]});
        end
    endtask : t_drive
    task automatic t_temp();
        logic [7:0] q;
        logic [2:0] r;
        logic [31:0] st;
        for (int i = 0; i < 8; i++) begin
            r = 3'(i + 4);
            sensor_rate <= r;
            repeat (3) @(posedge pclk);
            chk(high_temp, r[2]);
            mr(1'b1, MRL_ADDR_TEMP, 8'h00, q);
            chk(q, {5'h10, r});
            apb(1'b0, MRL_APB_STATUS, 32'h0, st);
            chk(st[9:0], {r == 3'h6, r == 3'h0 || r == 3'h7, 5'h10, r});
            mr(1'b1, MRL_ADDR_TEMP, 8'h00, q);
            chk(q, {5'h00, r});
        end
        sensor_rate <= 3'h1;
        repeat (3) @(posedge pclk);
        sensor_rate <= 3'h3;
        repeat (3) @(posedge pclk);
        mr(1'b1, MRL_ADDR_TEMP, 8'h00, q);
        chk(q, 8'h83);
    endtask : t_temp
    task automatic t_readback();
        logic [7:0] q;
        logic [31:0] st;
        mr(1'b1, MRL_ADDR_LAT, 8'h00, q);
        chk(q, MRL_UNDEF_DATA);
        mr(1'b1, MRL_ADDR_DRV, 8'h00, q);
        chk(q, MRL_UNDEF_DATA);
        mr(1'b1, MRL_ADDR_CAPS, 8'h00, q);
        chk(q, 8'hC0);
        mr(1'b0, MRL_ADDR_TEMP, 8'hFF, q);
        mr(1'b1, MRL_ADDR_TEMP, 8'h00, q);
        chk(q, 8'h03);
        apb(1'b0, 8'h14, 32'h0, st);
        chk(st, 32'h0);
    endtask : t_readback
    // Verdict and end of run
    task automatic final_report();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sensor_rate = 3'h3;
        error_cnt = 0;
        n_checks = 0;
        cycles = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_latency();
        t_drive();
        t_temp();
        t_readback();
        final_report();
    end
endmodule : mode_reg_latency_drive_temp_tb
`default_nettype wire
